// [urx_pkg.sv]
package urx_pkg;
  // bus geometry
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_RX_STATUS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_BAUD_CONTROL       = 8'h04;
  localparam logic [7:0] OFS_RATE_DIVISOR_LOW   = 8'h08;
  localparam logic [7:0] OFS_RATE_DIVISOR_HIGH  = 8'h0C;
  localparam logic [7:0] OFS_TX_STATUS_CONTROL  = 8'h10;
  localparam logic [7:0] OFS_RECEIVE_DATA_PORT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_CONTROL        = 8'h18;
  // receive status/control fields
  localparam int RS_SERIAL_PORT_ENABLE   = 7;
  localparam int RS_NINE_BIT_RECEIVE     = 6;
  localparam int RS_SINGLE_RECEIVE       = 5;
  localparam int RS_RX_CONT_ENABLE       = 4;
  localparam int RS_ADDRESS_FILTER       = 3;
  localparam int RS_STOP_BIT_ERROR       = 2;
  localparam int RS_FIFO_OVERFLOW        = 1;
  localparam int RS_NINTH_RECEIVED_BIT   = 0;
  // baud control fields
  localparam int BC_RECEIVER_IDLE        = 6;
  localparam int BC_WIDE_DIVISOR         = 3;
  localparam logic [7:0] BC_RW_MASK      = 8'h1B;
  // transmit status/control fields
  localparam int TS_SYNC_SELECT          = 4;
  localparam int TS_SHIFTER_EMPTY        = 1;
  localparam logic [7:0] TS_RW_MASK      = 8'hFD;
  // interrupt control fields
  localparam int IC_RECEIVE_IRQ_ENABLE   = 0;
  localparam int IC_PERIPHERAL_IRQ_ENABLE = 1;
  localparam int IC_GLOBAL_IRQ_ENABLE    = 2;
  localparam int IC_RECEIVE_PENDING      = 3;
  // reset values
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_DIVISOR     = 8'h00;
  // oversampling timing
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] START_DECIDE    = 4'h9;
  localparam logic [3:0] DATA_BITS_8     = 4'h8;
  localparam logic [3:0] DATA_BITS_9     = 4'h9;
  // fifo entry: {stop error, ninth bit, data[7:0]}
  localparam int ENTRY_W = 10;
  // receiver states, gray along idle-start-data-stop
  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } urx_state_t;
endpackage : urx_pkg

// [urx_fifo.sv]
`timescale 1ns/1ps
module urx_fifo
(
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         flush,
  input  wire logic                         push,
  input  wire logic [urx_pkg::ENTRY_W-1:0]  wdata,
  input  wire logic                         pop,
  output logic      [urx_pkg::ENTRY_W-1:0]  head,
  output logic                              empty,
  output logic                              full
);
  import urx_pkg::*;

  logic [ENTRY_W-1:0] entry_reg [2];
  logic [1:0]         count_reg;
  logic               do_pop;
  logic               do_push;

  assign head  = entry_reg[0];
  assign empty = (count_reg == 2'd0);
  assign full  = (count_reg == 2'd2);

  // a push into a full fifo is taken only when a pop frees a slot
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);

  // occupancy; a pop and a push in one cycle keep the count
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      count_reg <= 2'd0;
    else if (flush)
      count_reg <= 2'd0;
    else if (do_push && !do_pop)
      count_reg <= count_reg + 2'd1;
    else if (do_pop && !do_push)
      count_reg <= count_reg - 2'd1;

  // shift-style storage: entry 0 is always the oldest
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      entry_reg[0] <= '0;
      entry_reg[1] <= '0;
    end
    else if (flush)
    begin
      entry_reg[0] <= '0;
      entry_reg[1] <= '0;
    end
    else if (do_pop)
    begin
      // head keeps its last value when the fifo runs empty
      if (count_reg == 2'd2)
        entry_reg[0] <= entry_reg[1];
      else if (do_push)
        entry_reg[0] <= wdata;
      if (do_push && count_reg == 2'd2)
        entry_reg[1] <= wdata;
    end
    else if (do_push)
      entry_reg[count_reg[0]] <= wdata;
endmodule : urx_fifo

// [urx_receiver.sv]
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
// Functional notes
// - line sampled at sixteen ticks per bit; shifter advances once per bit
// - finished character moves at once into a two-entry fifo
// - receiver runs only with continuous enable, port enable, sync clear
// - falling edge, check low at half bit, else abandon silently
// - full bit time to each centre, majority decides, shift in
// - stop position sampled; low sets character stop error, high clears
// - after stop, push character, raise pending; data read pops oldest
// - pending equals enabled and fifo not empty; writes cannot touch
// - interrupt only with all three enables; pending updates regardless
// - stop error stored per entry; bit shows oldest entry
// - stop error never blocks reception, read-only, follows the fifo
// - port disable resets and clears stop error; receive disable does not
// - stop error alone raises no interrupt; stays set if all entries bad
// - third complete character with fifo full sets overflow error
// - overflow keeps fifo readable, blocks new; cleared only by disables
// - bits assembled least significant first, shared format and rate
// - nine-bit option takes nine bits; ninth shows for oldest entry
// - address filter in nine-bit mode keeps only ninth-bit-set characters
module urx_receiver
(
  input  wire logic                        CLK,
  input  wire logic                        RSTN,
  input  wire logic                        WB_CYC_I,
  input  wire logic                        WB_STB_I,
  input  wire logic                        WB_WE_I,
  input  wire logic [urx_pkg::ADR_W-1:0]   WB_ADR_I,
  input  wire logic [3:0]                  WB_SEL_I,
  input  wire logic [urx_pkg::DAT_W-1:0]   WB_DAT_I,
  output logic      [urx_pkg::DAT_W-1:0]   WB_DAT_O,
  output logic                             WB_ACK_O,
  input  wire logic                        RX_IN,
  output logic                             RX_IRQ
);
  import urx_pkg::*;

  logic [7:0]         rs_reg;
  logic [7:0]         bc_reg;
  logic [7:0]         brg_lo_reg;
  logic [7:0]         brg_hi_reg;
  logic [7:0]         ts_reg;
  logic [2:0]         ic_reg;
  logic               ovr_reg;
  logic [15:0]        div_reg;
  logic               tick_reg;
  logic [2:0]         samp_reg;
  logic [3:0]         cnt_reg;
  logic [3:0]         nbits_reg;
  logic [8:0]         shift_reg;
  urx_state_t         state_reg;
  logic               serial_port_enable;
  logic               receive_continuous_enable;
  logic               enabled;
  logic               maj;
  logic               decide;
  logic               push;
  logic               accept;
  logic               fifo_empty;
  logic               fifo_full;
  logic [ENTRY_W-1:0] fifo_head;
  logic [ENTRY_W-1:0] entry_next;
  logic               bus_req;
  logic               wr_lo;
  logic               rd_pop;
  logic               pending;
  logic [15:0]        div_top;
  logic [7:0]         rd_next;

  assign serial_port_enable    = rs_reg[RS_SERIAL_PORT_ENABLE];
  assign receive_continuous_enable    = rs_reg[RS_RX_CONT_ENABLE];
  assign enabled = serial_port_enable && receive_continuous_enable && !ts_reg[TS_SYNC_SELECT];
  assign pending = enabled && !fifo_empty;
  assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_lo   = bus_req && WB_WE_I && WB_SEL_I[0];
  assign rd_pop  = bus_req && !WB_WE_I &&
                   WB_ADR_I == OFS_RECEIVE_DATA_PORT;

  // register writes; status bits are not writable
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      rs_reg     <= RST_CONTROL;
      bc_reg     <= RST_CONTROL;
      brg_lo_reg <= RST_DIVISOR;
      brg_hi_reg <= RST_DIVISOR;
      ts_reg     <= RST_CONTROL;
      ic_reg     <= '0;
    end
    else if (wr_lo)
    begin
      unique case (WB_ADR_I)
        OFS_RX_STATUS_CONTROL: rs_reg <= WB_DAT_I[7:0] & 8'hF8;
        OFS_BAUD_CONTROL:      bc_reg <= WB_DAT_I[7:0] & BC_RW_MASK;
        OFS_RATE_DIVISOR_LOW:  brg_lo_reg <= WB_DAT_I[7:0];
        OFS_RATE_DIVISOR_HIGH: brg_hi_reg <= WB_DAT_I[7:0];
        OFS_TX_STATUS_CONTROL: ts_reg <= WB_DAT_I[7:0] & TS_RW_MASK;
        OFS_IRQ_CONTROL:       ic_reg <= WB_DAT_I[2:0];
        default:               ;
      endcase
    end

  // read mux of live state
  always_comb
  begin
    rd_next = 8'h00;
    unique case (WB_ADR_I)
      OFS_RX_STATUS_CONTROL:
        rd_next = {rs_reg[7:3], fifo_head[9], ovr_reg, fifo_head[8]};
      OFS_BAUD_CONTROL:
        rd_next = bc_reg | {1'b0, state_reg == RX_IDLE, 6'b0};
      OFS_RATE_DIVISOR_LOW:  rd_next = brg_lo_reg;
      OFS_RATE_DIVISOR_HIGH: rd_next = brg_hi_reg;
      OFS_TX_STATUS_CONTROL: rd_next = ts_reg | 8'h02;
      OFS_RECEIVE_DATA_PORT: rd_next = fifo_head[7:0];
      OFS_IRQ_CONTROL:       rd_next = {4'h0, pending, ic_reg};
      default:               rd_next = 8'h00;
    endcase
  end

  // wishbone answer one cycle after the request
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end
    else
    begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req ? {24'h0, rd_next} : '0;
    end

  // interrupt request gated by all enables; stop error plays no part
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      RX_IRQ <= 1'b0;
    else
      RX_IRQ <= pending && ic_reg[IC_RECEIVE_IRQ_ENABLE] &&
                ic_reg[IC_PERIPHERAL_IRQ_ENABLE] &&
                ic_reg[IC_GLOBAL_IRQ_ENABLE];

  // shared rate divisor makes the 16x oversampling tick
  assign div_top = bc_reg[BC_WIDE_DIVISOR] ? {brg_hi_reg, brg_lo_reg}
                                           : {8'h00, brg_lo_reg};
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (!serial_port_enable || div_reg >= div_top)
    begin
      div_reg  <= '0;
      tick_reg <= serial_port_enable;
    end
    else
    begin
      div_reg  <= div_reg + 16'd1;
      tick_reg <= 1'b0;
    end

  // three latest line samples for the vote
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      samp_reg <= 3'b111;
    else if (tick_reg)
      samp_reg <= {samp_reg[1:0], RX_IN};

  assign maj    = (samp_reg[0] & samp_reg[1]) | (samp_reg[1] & samp_reg[2]) |
                  (samp_reg[0] & samp_reg[2]);
  assign decide = tick_reg && ((state_reg == RX_START) ?
                  cnt_reg == START_DECIDE : cnt_reg == OVERSAMPLE_LAST);

  // bit timing and framing
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      state_reg <= RX_IDLE;
      cnt_reg   <= '0;
      nbits_reg <= '0;
      shift_reg <= '0;
    end
    else if (!enabled)
      state_reg <= RX_IDLE;
    else if (tick_reg)
    begin
      cnt_reg <= cnt_reg + 4'd1;
      unique case (state_reg)
        RX_IDLE:
          if (samp_reg[0] && !RX_IN)
          begin
            state_reg <= RX_START;
            cnt_reg   <= '0;
          end
        RX_START:
          if (decide)
          begin
            state_reg <= maj ? RX_IDLE : RX_DATA;
            cnt_reg   <= '0;
            nbits_reg <= '0;
          end
        RX_DATA:
          if (decide)
          begin
            cnt_reg   <= '0;
            nbits_reg <= nbits_reg + 4'd1;
            if (rs_reg[RS_NINE_BIT_RECEIVE])
              shift_reg <= {maj, shift_reg[8:1]};
            else
              shift_reg <= {1'b0, maj, shift_reg[7:1]};
            if (nbits_reg + 4'd1 == (rs_reg[RS_NINE_BIT_RECEIVE] ?
                DATA_BITS_9 : DATA_BITS_8))
              state_reg <= RX_STOP;
          end
        RX_STOP:
          if (decide)
          begin
            state_reg <= RX_IDLE;
            cnt_reg   <= '0;
          end
      endcase
    end

  // character complete: filter, push or overflow
  assign accept = !(rs_reg[RS_ADDRESS_FILTER] &&
                    rs_reg[RS_NINE_BIT_RECEIVE] && !shift_reg[8]);
  assign push   = enabled && state_reg == RX_STOP && decide && accept &&
                  !ovr_reg && (!fifo_full || rd_pop);
  assign entry_next = {!maj, shift_reg};

  // overflow sticks until a receive or port disable
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      ovr_reg <= 1'b0;
    else if (!receive_continuous_enable || !serial_port_enable)
      ovr_reg <= 1'b0;
    else if (enabled && state_reg == RX_STOP && decide && accept &&
             fifo_full && !rd_pop)
      ovr_reg <= 1'b1;

  urx_fifo u_fifo
  (
    .clk   (CLK),
    .rstn  (RSTN),
    .flush (!serial_port_enable),
    .push  (push),
    .wdata (entry_next),
    .pop   (rd_pop),
    .head  (fifo_head),
    .empty (fifo_empty),
    .full  (fifo_full)
  );

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_start_abort: assert property (
    state_reg == RX_START && decide && maj && enabled |=> state_reg == RX_IDLE)
    else $error("false start not abandoned");
  a_vote_two: assert property (
    decide && $countones(samp_reg) >= 2 |-> maj)
    else $error("majority vote wrong");
  a_bit_centre: assert property (
    state_reg == RX_DATA && decide |-> cnt_reg == OVERSAMPLE_LAST)
    else $error("bit not sixteen ticks");
  a_push_stop: assert property (
    push |-> state_reg == RX_STOP && !ovr_reg)
    else $error("push outside stop");
  a_ovr_set: assert property (
    enabled && state_reg == RX_STOP && decide && accept && fifo_full &&
    !rd_pop |=> ovr_reg) else $error("overflow missed");
  a_ovr_clear: assert property (
    !receive_continuous_enable |=> !ovr_reg)
    else $error("overflow not cleared");
  a_port_off: assert property (
    !serial_port_enable |=> fifo_empty && !fifo_head[9])
    else $error("port disable kept state");
  a_irq_gate: assert property (
    RX_IRQ |-> $past(pending) && $past(ic_reg) == 3'h7)
    else $error("interrupt without enables");
  a_filter_nine: assert property (
    push && rs_reg[RS_ADDRESS_FILTER] && rs_reg[RS_NINE_BIT_RECEIVE]
    |-> shift_reg[8]) else $error("filter leak");
  a_pend_pop: assert property (
    pending && rd_pop && !push && !fifo_full |=> !pending)
    else $error("pop kept pending");

  c_push: cover property (push);
  c_abort: cover property (state_reg == RX_START ##1 state_reg == RX_IDLE);
  c_overflow: cover property (!ovr_reg ##1 ovr_reg);
  c_stop_error: cover property (push && entry_next[9]);
endmodule : urx_receiver

// [urx_line_model.sv]
`timescale 1ns/1ps
module urx_line_model
#(
  parameter int BIT_CYCLES = 16
)
(
  input  wire logic clk,
  output logic      line
);
  // clock cycles per bit, changed by the bench for other rates
  int bit_cycles = BIT_CYCLES;

  // line rests at the mark level between frames
  initial line = 1'b1;

  // hold one level for a whole bit time
  task automatic drive(input logic v);
    @(posedge clk);
    line <= v;
    repeat (bit_cycles - 1) @(posedge clk);
  endtask : drive

  // start, data lsb first, stop at the asked level, one idle bit
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic stop_level);
    int i;
    drive(1'b0);
    for (i = 0; i < nbits; i++)
      drive(data[i]);
    drive(stop_level);
    drive(1'b1);
  endtask : send

  // short low pulse that must not pass as a start bit
  task automatic glitch();
    @(posedge clk);
    line <= 1'b0;
    repeat (3) @(posedge clk);
    line <= 1'b1;
    repeat (2 * bit_cycles) @(posedge clk);
  endtask : glitch
endmodule : urx_line_model

// [tb_urx_receiver.sv]
`timescale 1ns/1ps
module tb_urx_receiver;
  import urx_pkg::*;
  logic              clk;
  logic              rstn;
  logic              cyc;
  logic              stb;
  logic              we;
  logic [ADR_W-1:0]  adr;
  logic [3:0]        sel;
  logic [DAT_W-1:0]  wdat;
  logic [DAT_W-1:0]  rdat;
  logic              ack;
  logic              rx_line;
  logic              irq;
  int                mismatches;
  int                comparisons;
  int                cycles;

  urx_receiver i_urx_receiver
  (
    .CLK      (clk),
    .RSTN     (rstn),
    .WB_CYC_I (cyc),
    .WB_STB_I (stb),
    .WB_WE_I  (we),
    .WB_ADR_I (adr),
    .WB_SEL_I (sel),
    .WB_DAT_I (wdat),
    .WB_DAT_O (rdat),
    .WB_ACK_O (ack),
    .RX_IN    (rx_line),
    .RX_IRQ   (irq)
  );

  urx_line_model i_urx_line_model
  (
    .clk  (clk),
    .line (rx_line)
  );

  // clock at 200 MHz
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic conclude();
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [31:0] got,
                       input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    check(name, q, exp);
  endtask : rd_chk

  task automatic t_reset();
    rd_chk("rxsc", OFS_RX_STATUS_CONTROL, 32'h0000_0000);
    rd_chk("txsc", OFS_TX_STATUS_CONTROL, 32'h0000_0002);
    rd_chk("hole", 8'h1C, 32'h0000_0000);
    rd_chk("bcrst", OFS_BAUD_CONTROL, 32'h0000_0040);
    wr(OFS_BAUD_CONTROL, 32'h0000_00FF);
    rd_chk("bcrw", OFS_BAUD_CONTROL, 32'h0000_005B);
    wr(OFS_BAUD_CONTROL, 32'h0000_0000);
    wr(OFS_RATE_DIVISOR_LOW, 32'h0000_005A);
    rd_chk("divl", OFS_RATE_DIVISOR_LOW, 32'h0000_005A);
    wr(OFS_RATE_DIVISOR_LOW, 32'h0000_0000);
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0007);
    rd_chk("rxro", OFS_RX_STATUS_CONTROL, 32'h0000_0000);
    wr(OFS_IRQ_CONTROL, 32'h0000_0008);
    rd_chk("pendw", OFS_IRQ_CONTROL, 32'h0000_0000);
  endtask : t_reset

  task automatic t_basic();
    logic [31:0] v;
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0090);
    i_urx_line_model.send(9'h0A5, 8, 1'b1);
    rd_chk("pend", OFS_IRQ_CONTROL, 32'h0000_0008);
    for (v = 0; v < 8; v++)
    begin
      wr(OFS_IRQ_CONTROL, v);
      repeat (2) @(posedge clk);
      check("irq", {31'h0, irq}, {31'h0, v == 7});
    end
    rd_chk("data", OFS_RECEIVE_DATA_PORT, 32'h0000_00A5);
    rd_chk("pend0", OFS_IRQ_CONTROL, 32'h0000_0007);
    repeat (2) @(posedge clk);
    check("irq0", {31'h0, irq}, 32'h0000_0000);
    wr(OFS_IRQ_CONTROL, 32'h0000_0000);
  endtask : t_basic

  task automatic t_glitch();
    i_urx_line_model.glitch();
    rd_chk("gpend", OFS_IRQ_CONTROL, 32'h0000_0000);
    rd_chk("gstat", OFS_RX_STATUS_CONTROL, 32'h0000_0090);
    i_urx_line_model.send(9'h03C, 8, 1'b1);
    rd_chk("gdata", OFS_RECEIVE_DATA_PORT, 32'h0000_003C);
  endtask : t_glitch

  task automatic t_overrun();
    i_urx_line_model.send(9'h011, 8, 1'b0);
    i_urx_line_model.send(9'h022, 8, 1'b1);
    i_urx_line_model.send(9'h033, 8, 1'b1);
    // status first, then data
    rd_chk("ostat", OFS_RX_STATUS_CONTROL, 32'h0000_0096);
    rd_chk("od1", OFS_RECEIVE_DATA_PORT, 32'h0000_0011);
    rd_chk("ostat2", OFS_RX_STATUS_CONTROL, 32'h0000_0092);
    i_urx_line_model.send(9'h044, 8, 1'b1);
    rd_chk("od2", OFS_RECEIVE_DATA_PORT, 32'h0000_0022);
    rd_chk("opend", OFS_IRQ_CONTROL, 32'h0000_0000);
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0080);
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0090);
    rd_chk("oclr", OFS_RX_STATUS_CONTROL, 32'h0000_0090);
  endtask : t_overrun

  task automatic t_frame();
    i_urx_line_model.send(9'h055, 8, 1'b0);
    i_urx_line_model.send(9'h066, 8, 1'b0);
    rd_chk("fst1", OFS_RX_STATUS_CONTROL, 32'h0000_0094);
    rd_chk("fd1", OFS_RECEIVE_DATA_PORT, 32'h0000_0055);
    rd_chk("fst2", OFS_RX_STATUS_CONTROL, 32'h0000_0094);
    rd_chk("fd2", OFS_RECEIVE_DATA_PORT, 32'h0000_0066);
    i_urx_line_model.send(9'h077, 8, 1'b0);
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0080);
    rd_chk("fcr", OFS_RX_STATUS_CONTROL, 32'h0000_0084);
    rd_chk("fpd", OFS_IRQ_CONTROL, 32'h0000_0000);
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0000);
    rd_chk("fsp", OFS_RX_STATUS_CONTROL, 32'h0000_0000);
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0090);
    rd_chk("ffl", OFS_IRQ_CONTROL, 32'h0000_0000);
  endtask : t_frame

  task automatic t_nine();
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_00D8);
    i_urx_line_model.send(9'h0AA, 9, 1'b1);
    i_urx_line_model.send(9'h1BB, 9, 1'b1);
    rd_chk("nst", OFS_RX_STATUS_CONTROL, 32'h0000_00D9);
    rd_chk("nd", OFS_RECEIVE_DATA_PORT, 32'h0000_00BB);
    rd_chk("npd", OFS_IRQ_CONTROL, 32'h0000_0000);
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_00D0);
    i_urx_line_model.send(9'h0CC, 9, 1'b1);
    rd_chk("nst2", OFS_RX_STATUS_CONTROL, 32'h0000_00D0);
    rd_chk("nd2", OFS_RECEIVE_DATA_PORT, 32'h0000_00CC);
    // synchronous select keeps the receiver off
    wr(OFS_RX_STATUS_CONTROL, 32'h0000_0090);
    wr(OFS_TX_STATUS_CONTROL, 32'h0000_0010);
    i_urx_line_model.send(9'h012, 8, 1'b1);
    rd_chk("spd", OFS_IRQ_CONTROL, 32'h0000_0000);
    wr(OFS_TX_STATUS_CONTROL, 32'h0000_0000);
    rd_chk("spd2", OFS_IRQ_CONTROL, 32'h0000_0000);
  endtask : t_nine

  // divisor of one: tick every second cycle, 32 cycles per bit
  task automatic t_rate();
    wr(OFS_RATE_DIVISOR_HIGH, 32'h0000_0001);
    wr(OFS_RATE_DIVISOR_LOW, 32'h0000_0001);
    i_urx_line_model.bit_cycles = 32;
    i_urx_line_model.send(9'h05C, 8, 1'b1);
    rd_chk("rnar", OFS_RECEIVE_DATA_PORT, 32'h0000_005C);
    wr(OFS_RATE_DIVISOR_HIGH, 32'h0000_0000);
    wr(OFS_BAUD_CONTROL, 32'h0000_0008);
    i_urx_line_model.send(9'h0C3, 8, 1'b1);
    rd_chk("rwid", OFS_RECEIVE_DATA_PORT, 32'h0000_00C3);
    wr(OFS_BAUD_CONTROL, 32'h0000_0000);
    wr(OFS_RATE_DIVISOR_LOW, 32'h0000_0000);
    i_urx_line_model.bit_cycles = 16;
  endtask : t_rate

  // reset, then the scenarios in turn
  initial
  begin
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'h0;
    wdat = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_basic();
    t_glitch();
    t_overrun();
    t_frame();
    t_nine();
    t_rate();
    conclude();
  end
endmodule : tb_urx_receiver
